// ---- logic/rbs_top.sv ----
// Operation
// - Any listed reset source resets the core.
// - Hold core while supply not acceptable.
// - Power-up delay lasts nominal 64 ms.
// - Delay holds reset; enabled when bit low.
// - Delay starts after power and brown-out release.
// - Two-bit field picks one of four modes.
// - Always-on: start waits ready, wake undelayed.
// - Off-in-sleep: no detection asleep, wake waits ready.
// - Software mode: enable bit, no start wait.
// - Software mode protects once circuit ready.
// - Detection off: start at once after release.
// - Forced-on modes also hold start until circuit ready.
// - Brown-out only after dip exceeds filter time.
// - Configuration bit picks brown-out threshold level.
// - Bit 7 software enable, always read/write.
// - Fast start forces band gap in two modes.
// - Bit 0 ready flag; bits 5-1 zero.
// - Low-power request ORed into generic brown-out.
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module rbs_top import rbs_pkg::*; #(
    parameter logic [POWER_UP_DELAY_TIMER_W-1:0] POWER_UP_DELAY_TIMER_CYCLES = POWER_UP_DELAY_TIMER_CYC[POWER_UP_DELAY_TIMER_W-1:0]
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Configuration word bits, static
    input wire logic [1:0] brownout_mode_select,
    input wire logic power_up_delay_enable_n,
    input wire logic brownout_level_select,
    // Analog detector indications, asynchronous
    input wire logic supply_ok,
    input wire logic below_threshold,
    input wire logic brownout_circuit_ready,
    input wire logic low_power_brownout,
    // Other reset sources and sleep state, synchronous
    input wire logic external_reset_pin_n,
    input wire logic watchdog_reset,
    input wire logic reset_instruction,
    input wire logic stack_overflow,
    input wire logic stack_underflow,
    input wire logic program_exit,
    input wire logic sleep_mode,
    // Outputs to core and analog
    output logic core_reset,
    output logic brownout_reset,
    output logic brownout_detect_en,
    output logic bandgap_force_on,
    output logic brownout_level_out,
    output logic wake_hold
);
    // Whole state of the block
    typedef struct packed {
        rbs_state_e state;
        logic tmr_start;
        logic [FILT_W-1:0] filt_cnt;
        logic bor_req;
        logic det_en;
        logic sbor;
        logic fast;
        logic [7:0] rdata;
        logic core_reset;
        logic bor_gen;
        logic bandgap;
        logic level;
        logic wake_hold;
    } rbs_top_s;

    rbs_top_s st_q;
    rbs_top_s st_d;

    // Synchronised analog levels
    logic [3:0] ana_s;
    logic ok_s;
    logic below_s;
    logic ready_s;
    logic lp_s;
    logic tmr_busy;
    logic por_event;
    logic other_rst;
    logic waits_ready;
    logic armed;
    logic ctl_hit_wr;
    logic ctl_hit_rd;

    // Analog crossing; nothing reads the first stage
    rbs_sync #(
        .WIDTH(4)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .din({low_power_brownout, brownout_circuit_ready, below_threshold, supply_ok}),
        .dout(ana_s)
    );

    assign ok_s = ana_s[0];
    assign below_s = ana_s[1];
    assign ready_s = ana_s[2];
    assign lp_s = ana_s[3];

    // Power-up delay counter
    rbs_timer u_timer (
        .clk(clk),
        .nrst(nrst),
        .cycles(POWER_UP_DELAY_TIMER_CYCLES),
        .start(st_q.tmr_start),
        .busy(tmr_busy)
    );

    // Power or brown-out, or programming exit which acts as power-on
    assign por_event = !ok_s || st_q.bor_gen || program_exit;
    // Sources that hold the core but do not restart the sequence
    assign other_rst = !external_reset_pin_n || watchdog_reset || reset_instruction
        || stack_overflow || stack_underflow;
    // Start waits for ready only where the circuit is forced on
    assign waits_ready = (brownout_mode_select == MODE_ON)
        || (brownout_mode_select == MODE_NOSLP);
    // Detector only protects once the circuit is ready
    assign armed = st_q.det_en && ready_s;
    assign ctl_hit_wr = reg_wr && (reg_addr == CTL_ADDR);
    assign ctl_hit_rd = reg_rd && (reg_addr == CTL_ADDR);

    // Next state
    always_comb begin
        st_d = st_q;
        st_d.tmr_start = 1'b0;

        // Detector enable per mode
        unique case (brownout_mode_select)
            MODE_ON: st_d.det_en = 1'b1;
            MODE_NOSLP: st_d.det_en = !sleep_mode;
            MODE_SW: st_d.det_en = st_q.sbor;
            MODE_OFF: st_d.det_en = 1'b0;
        endcase

        // Noise filter: count a dip, fire once it outlasts the filter
        if (armed && below_s) begin
            if (st_q.filt_cnt != FILT_CYC[FILT_W-1:0]) begin
                st_d.filt_cnt = st_q.filt_cnt + 1'b1;
            end
            st_d.bor_req = st_q.bor_req
                || (st_q.filt_cnt == FILT_CYC[FILT_W-1:0]);
        end else begin
            st_d.filt_cnt = '0;
            st_d.bor_req = 1'b0;
        end

        // Generic brown-out takes the low-power request too
        st_d.bor_gen = st_d.bor_req || lp_s;

        // Start-up sequence
        unique case (st_q.state)
            ST_HOLD: begin
                // Both releases needed before the delay may run
                if (!por_event) begin
                    if (!power_up_delay_enable_n) begin
                        st_d.state = ST_DELAY;
                        st_d.tmr_start = 1'b1;
                    end else begin
                        st_d.state = ST_WAIT;
                    end
                end
            end
            ST_DELAY: begin
                // Held while the delay counter runs
                if (!st_q.tmr_start && !tmr_busy) begin
                    st_d.state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // Forced-on modes wait for ready and good supply
                if (!waits_ready || (ready_s && !below_s)) begin
                    st_d.state = ST_RUN;
                end
            end
            ST_RUN: begin
                st_d.state = ST_RUN;
            end
        endcase
        // Power or brown-out always wins and restarts the sequence
        if (por_event) begin
            st_d.state = ST_HOLD;
            st_d.tmr_start = 1'b0;
        end

        // Core reset from the next state so it follows without lag
        st_d.core_reset = (st_d.state != ST_RUN) || other_rst;

        // Fast start only counts in the two switchable modes
        st_d.bandgap = st_q.fast && ((brownout_mode_select == MODE_NOSLP)
            || (brownout_mode_select == MODE_SW));
        st_d.level = brownout_level_select;
        // Wake delayed for ready only in off-in-sleep mode
        st_d.wake_hold = (brownout_mode_select == MODE_NOSLP) && !ready_s;

        // Register writes; both bits stored in every mode
        if (ctl_hit_wr) begin
            st_d.sbor = reg_wdata[SBOR_BIT];
            st_d.fast = reg_wdata[FAST_BIT];
        end

        // Read data valid the cycle after the strobe; unmapped reads zero
        st_d.rdata = '0;
        if (ctl_hit_rd) begin
            st_d.rdata[SBOR_BIT] = st_q.sbor;
            st_d.rdata[FAST_BIT] = st_q.fast;
            st_d.rdata[RDY_BIT] = armed;
        end
    end

    // Registers; reset holds the core and restarts the sequence
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q <= '0;
            st_q.state <= ST_HOLD;
            st_q.core_reset <= 1'b1;
            st_q.sbor <= SBOR_RST;
            st_q.fast <= FAST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from flops
    assign reg_rdata = st_q.rdata;
    assign core_reset = st_q.core_reset;
    assign brownout_reset = st_q.bor_gen;
    assign brownout_detect_en = st_q.det_en;
    assign bandgap_force_on = st_q.bandgap;
    assign brownout_level_out = st_q.level;
    assign wake_hold = st_q.wake_hold;

    // Checks
    sequence short_dip_s;
        !st_q.bor_req && !below_s ##1 below_s ##1 !below_s;
    endsequence

    sequence delay_begin_s;
        st_q.tmr_start ##1 (tmr_busy && st_q.state == ST_DELAY);
    endsequence

    supply_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        !ok_s |=> core_reset)
        else $error("core not held while supply low");

    delay_start_a: assert property (@(posedge clk) disable iff (!nrst)
        st_q.tmr_start |-> delay_begin_s ##1 core_reset)
        else $error("power-up delay did not start");

    delay_off_a: assert property (@(posedge clk) disable iff (!nrst)
        power_up_delay_enable_n |-> !st_q.tmr_start && st_q.state != ST_DELAY)
        else $error("delay ran while disabled");

    start_release_a: assert property (@(posedge clk) disable iff (!nrst)
        st_q.tmr_start |-> $past(ok_s) && !$past(st_q.bor_gen))
        else $error("delay started before release");

    mode_off_a: assert property (@(posedge clk) disable iff (!nrst)
        brownout_mode_select == MODE_OFF |=> !brownout_detect_en)
        else $error("detector on in off mode");

    wait_ready_a: assert property (@(posedge clk) disable iff (!nrst)
        st_q.state == ST_WAIT && waits_ready && !ready_s && !por_event
        |=> st_q.state == ST_WAIT && core_reset)
        else $error("start did not wait for ready");

    short_dip_a: assert property (@(posedge clk) disable iff (!nrst)
        short_dip_s |=> !st_q.bor_req)
        else $error("short dip caused brown-out");

    soft_en_a: assert property (@(posedge clk) disable iff (!nrst)
        ctl_hit_wr ##1 ctl_hit_rd |=> reg_rdata[SBOR_BIT] == $past(reg_wdata[SBOR_BIT], 2))
        else $error("software enable not read back");

    fast_off_a: assert property (@(posedge clk) disable iff (!nrst)
        brownout_mode_select == MODE_ON |=> !bandgap_force_on)
        else $error("fast start active in always-on mode");

    zero_bits_a: assert property (@(posedge clk) disable iff (!nrst)
        reg_rd |=> reg_rdata[5:1] == 5'h00)
        else $error("reserved bits not zero");

    lp_or_a: assert property (@(posedge clk) disable iff (!nrst)
        lp_s |=> brownout_reset ##1 core_reset)
        else $error("low-power request not merged");

    // Threshold select is a plain one-cycle copy; skip the edge after reset
    level_copy_a: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) |-> brownout_level_out == $past(brownout_level_select))
        else $error("threshold select not passed on");

    // Always-on mode never delays wake-up
    wake_free_a: assert property (@(posedge clk) disable iff (!nrst)
        brownout_mode_select == MODE_ON |=> !wake_hold)
        else $error("wake delayed in always-on mode");

    // Fast start has no effect in always-off mode either
    fast_idle_a: assert property (@(posedge clk) disable iff (!nrst)
        brownout_mode_select == MODE_OFF |=> !bandgap_force_on)
        else $error("fast start active in always-off mode");
endmodule

// ---- logic/rbs_pkg.sv ----
package rbs_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int POWER_UP_DELAY_TIMER_MS = 64;
    localparam int POWER_UP_DELAY_TIMER_CYC = POWER_UP_DELAY_TIMER_MS * 1000000 / CLK_PERIOD_NS;
    localparam int FILT_NS = 1000;
    localparam int FILT_CYC = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWER_UP_DELAY_TIMER_W = 22;
    localparam int FILT_W = 7;

    // Register port
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] CTL_ADDR = 4'h0;
    localparam int SBOR_BIT = 7;
    localparam int FAST_BIT = 6;
    localparam int RDY_BIT = 0;
    localparam logic SBOR_RST = 1'h1;
    localparam logic FAST_RST = 1'h0;

    // Brown-out mode field codes
    localparam logic [1:0] MODE_ON = 2'h3;
    localparam logic [1:0] MODE_NOSLP = 2'h2;
    localparam logic [1:0] MODE_SW = 2'h1;
    localparam logic [1:0] MODE_OFF = 2'h0;

    // Start-up sequence states, one-hot
    typedef enum logic [3:0] {
        ST_HOLD = 4'h1,
        ST_DELAY = 4'h2,
        ST_WAIT = 4'h4,
        ST_RUN = 4'h8
    } rbs_state_e;
endpackage

// ---- logic/rbs_sync.sv ----
`timescale 1ns/1ps
module rbs_sync import rbs_pkg::*; #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    // Two flop stages; the first one feeds nothing but the second
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } rbs_sync_s;

    rbs_sync_s st_q;
    rbs_sync_s st_d;

    // Next state: shift one stage per clock
    always_comb begin
        st_d.meta = din;
        st_d.sync = st_q.meta;
    end

    // Registers, cleared in reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign dout = st_q.sync;
endmodule

// ---- logic/rbs_timer.sv ----
`timescale 1ns/1ps
module rbs_timer import rbs_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Length and control
    input wire logic [POWER_UP_DELAY_TIMER_W-1:0] cycles,
    input wire logic start,
    output logic busy
);
    // Down counter; busy while not zero
    typedef struct packed {
        logic [POWER_UP_DELAY_TIMER_W-1:0] cnt;
    } rbs_timer_s;

    rbs_timer_s st_q;
    rbs_timer_s st_d;

    // Load on start, else count down to zero
    always_comb begin
        st_d = st_q;
        if (start) begin
            st_d.cnt = cycles;
        end else if (st_q.cnt != '0) begin
            st_d.cnt = st_q.cnt - 1'b1;
        end
    end

    // Registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign busy = (st_q.cnt != '0);
endmodule

// ---- tb/test_rbs_top.sv ----
`timescale 1ns/1ps
module test_rbs_top import rbs_pkg::*;;
    // Short delay so the run stays brief
    localparam int PW = 20;
    // Compare, count, report at once
    `define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_fail++; \
        $display("ERROR %0t mismatch got %h exp %h", $time, got, exp); end end
    logic clk, nrst, reg_wr, reg_rd, pd_en_n, lvl, ok, below, rdy, lpb, slp;
    logic [ADDR_W-1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [1:0] mode;
    // Other reset sources, one bit each
    logic [5:0] src;
    logic core_reset, brownout_reset, det_en, bg_on, lvl_out, wake_hold;
    int n_fail = 0;
    int checked = 0;

    rbs_top #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER_W'(PW))) DUT (
        .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .brownout_mode_select(mode), .power_up_delay_enable_n(pd_en_n),
        .brownout_level_select(lvl), .supply_ok(ok), .below_threshold(below),
        .brownout_circuit_ready(rdy), .low_power_brownout(lpb),
        .external_reset_pin_n(~src[4]), .watchdog_reset(src[0]),
        .reset_instruction(src[1]), .stack_overflow(src[2]), .stack_underflow(src[3]),
        .program_exit(src[5]), .sleep_mode(slp), .core_reset(core_reset),
        .brownout_reset(brownout_reset), .brownout_detect_en(det_en),
        .bandgap_force_on(bg_on), .brownout_level_out(lvl_out), .wake_hold(wake_hold));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // One-cycle write strobe
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // Write, then read back on the very next cycle with no gap
    task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [7:0] v,
        output logic [7:0] r);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 r = reg_rdata;
    endtask

    // Settle a few edges, then sample
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Bounded wait on core reset; count must land in [lo, hi]
    task automatic wait_core(input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while (core_reset !== v && n < hi) begin
            @(posedge clk);
            #1 n++;
        end
        `CHK(core_reset, v)
        `CHK(n >= lo, 1'b1)
    endtask

    // Closing report, the only way out
    task automatic print_verdict();
        $display("checked %0d, n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog against a hung sequence
    initial begin
        #200000;
        n_fail++;
        print_verdict();
    end

    initial begin
        {nrst, reg_wr, reg_rd, lvl, ok, below, rdy, lpb, slp} = '0;
        {reg_addr, reg_wdata, mode, src} = '0;
        pd_en_n = 1'b1;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        // Registers: reset value, reserved bits, unmapped place
        cyc(1);
        `CHK(core_reset, 1'b1)
        rd(CTL_ADDR, d);
        `CHK(d, 8'h80)
        wr_rd(CTL_ADDR, 8'hff, d);
        `CHK(d, 8'hc0)
        wr(4'h3, 8'h00);
        rd(4'h3, d);
        `CHK(d, 8'h00)
        rd(CTL_ADDR, d);
        `CHK(d, 8'hc0)
        $display("test registers done");
        // Start-up without delay, then supply loss
        @(posedge clk) ok <= 1'b1;
        wait_core(1'b0, 1, 8);
        @(posedge clk) ok <= 1'b0;
        wait_core(1'b1, 0, 6);
        // Power-up delay holds reset for its full length
        @(posedge clk) pd_en_n <= 1'b0;
        ok <= 1'b1;
        wait_core(1'b0, PW, PW + 10);
        // Each other source holds reset; only program exit restarts the delay
        for (int i = 0; i < 6; i++) begin
            @(posedge clk) src <= 6'h01 << i;
            cyc(3);
            `CHK(core_reset, 1'b1)
            @(posedge clk) src <= 6'h00;
            wait_core(1'b0, (i == 5) ? PW : 0, (i == 5) ? PW + 10 : 6);
        end
        $display("test startup done");
        // Always-on start waits for ready
        @(posedge clk) ok <= 1'b0;
        pd_en_n <= 1'b1;
        mode <= MODE_ON;
        cyc(4);
        @(posedge clk) ok <= 1'b1;
        cyc(20);
        `CHK(core_reset, 1'b1)
        @(posedge clk) rdy <= 1'b1;
        wait_core(1'b0, 1, 8);
        wr(CTL_ADDR, 8'h00);
        rd(CTL_ADDR, d);
        `CHK(d, 8'h01)
        // Short dip ignored, long dip resets
        @(posedge clk) below <= 1'b1;
        cyc(40);
        @(posedge clk) below <= 1'b0;
        cyc(60);
        `CHK(brownout_reset, 1'b0)
        @(posedge clk) below <= 1'b1;
        cyc(45);
        `CHK(brownout_reset, 1'b0)
        cyc(15);
        `CHK(brownout_reset, 1'b1)
        `CHK(core_reset, 1'b1)
        @(posedge clk) below <= 1'b0;
        wait_core(1'b0, 1, 12);
        // Low-power request joins the generic brown-out
        @(posedge clk) lpb <= 1'b1;
        cyc(4);
        `CHK(brownout_reset, 1'b1)
        @(posedge clk) lpb <= 1'b0;
        wait_core(1'b0, 1, 12);
        $display("test brownout done");
        // Every mode with enable and fast start set
        wr(CTL_ADDR, 8'hc0);
        for (int m = 0; m < 4; m++) begin
            @(posedge clk) mode <= m[1:0];
            cyc(4);
            `CHK(det_en, m != 0)
            `CHK(bg_on, m == 1 || m == 2)
        end
        // Sleep only stops detection in off-in-sleep mode
        @(posedge clk) slp <= 1'b1;
        cyc(4);
        `CHK(det_en, 1'b1)
        @(posedge clk) mode <= MODE_NOSLP;
        rdy <= 1'b0;
        lvl <= 1'b1;
        cyc(4);
        `CHK(det_en, 1'b0)
        `CHK(wake_hold, 1'b1)
        `CHK(lvl_out, 1'b1)
        @(posedge clk) mode <= MODE_SW;
        rdy <= 1'b1;
        cyc(4);
        `CHK(det_en, 1'b1)
        `CHK(wake_hold, 1'b0)
        // Software mode with enable cleared
        @(posedge clk) slp <= 1'b0;
        wr(CTL_ADDR, 8'h40);
        cyc(3);
        `CHK(det_en, 1'b0)
        rd(CTL_ADDR, d);
        `CHK(d, 8'h40)
        // Mid-run reset holds the core and restores the register
        @(posedge clk) nrst <= 1'b0;
        cyc(2);
        `CHK(core_reset, 1'b1)
        @(posedge clk) nrst <= 1'b1;
        rd(CTL_ADDR, d);
        `CHK(d, 8'h80)
        $display("test modes done");
        print_verdict();
    end
endmodule
